/* bops_blank_timer.sv */
`timescale 1ns/10ps
module bops_blank_timer #(
  parameter logic [11:0] LIMIT = 12'h001
) (
  // Clock and control
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic clk_en,
  // Condition and result
  input  wire logic cond,
  output logic      expired
);

  logic [11:0] cnt_ff;
  logic [11:0] nxt_cnt;
  logic        expired_ff;

  // Any break in the condition restarts the count
  always_comb begin
    nxt_cnt = 12'h000;
    if (cond) begin
      nxt_cnt = (cnt_ff == LIMIT) ? cnt_ff : cnt_ff + 12'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_ff     <= 12'h000;
      expired_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff     <= nxt_cnt;
      expired_ff <= (nxt_cnt == LIMIT);
    end
  end

  assign expired = expired_ff;

endmodule : bops_blank_timer

/* bops_defines.svh */
// How it works
// - Three burst options: none, low range, high range, picked by select resistor.
// - Low option: peak 0.22 V, entry 0.93 V, exit 2.73 V.
// - High option: peak 0.27 V, entry 1.03 V, exit 2.73 V.
// - First power-up presets high option, pull-up off, selection current on.
// - Select current flows from 4.44 V to turn-on, then feedback is sampled.
// - Chosen option stays latched; current source off, pull-up reconnected.
// - Error-input bias before turn-on; above 0.2 V means non-isolated mode.
// - Isolated mode disconnects the error amplifier; non-isolated connects it.
// - Fault checks enabled per state as the protection table gives.
// - Switch held off after 50 us undervoltage or 55 us overvoltage.
// - Undervoltage restarts startup; turn-on resumes with a new soft start.
// - Overload held past its blanking time leads to odd-skip auto-restart.
// - Overtemperature gives non-switching restart until 40 C hysteresis clears.
// - Three consecutive shorted-sense pulses give odd-skip auto-restart.
// - Every fault restarts automatically with a fresh soft start.
// - Burst entered only after feedback stays below entry level for blanking.
// - Feedback above exit level leaves burst and restores normal peak at once.
`ifndef BOPS_DEFINES_SVH
`define BOPS_DEFINES_SVH

// Clock rate and timing figures
`define BOPS_CLK_MHZ        40
`define BOPS_T_UV_US        50
`define BOPS_T_OVP_US       55
`define BOPS_T_OLP_US       20
`define BOPS_T_BURST_US     20
`define BOPS_T_RESTART_US   100
`define BOPS_T_CS_BLANK_NS  200

// Cycle counts derived from the figures, least times rounded up
`define BOPS_N_UV       12'(`BOPS_T_UV_US * `BOPS_CLK_MHZ)
`define BOPS_N_OVP      12'(`BOPS_T_OVP_US * `BOPS_CLK_MHZ)
`define BOPS_N_OLP      12'(`BOPS_T_OLP_US * `BOPS_CLK_MHZ)
`define BOPS_N_BURST    12'(`BOPS_T_BURST_US * `BOPS_CLK_MHZ)
`define BOPS_N_RESTART  12'(`BOPS_T_RESTART_US * `BOPS_CLK_MHZ)
`define BOPS_N_CS_BLANK 12'((`BOPS_T_CS_BLANK_NS * `BOPS_CLK_MHZ + 999) / 1000)

// Burst levels in millivolts
`define BOPS_MV_PEAK_LOW   12'h0dc
`define BOPS_MV_PEAK_HIGH  12'h10e
`define BOPS_MV_ENTRY_LOW  12'h3a2
`define BOPS_MV_ENTRY_HIGH 12'h406
`define BOPS_MV_EXIT       12'haaa
`define BOPS_MV_NONE       12'h000

// Consecutive shorted pulses before the fault
`define BOPS_SHORT_PULSES  2'h3

`endif

/* bops_pkg.sv */
package bops_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_SELECT    = 3'b000,
    ST_NORMAL    = 3'b001,
    ST_BURST_ON  = 3'b010,
    ST_BURST_OFF = 3'b011,
    ST_RESTART   = 3'b100
  } bops_state_t;

  // Light-load burst options
  typedef enum logic [1:0] {
    OPT_NONE = 2'b00,
    OPT_LOW  = 2'b01,
    OPT_HIGH = 2'b10
  } bops_opt_t;

  // Auto-restart flavours
  typedef enum logic [1:0] {
    AR_PLAIN      = 2'b00,
    AR_ODD_SKIP   = 2'b01,
    AR_NON_SWITCH = 2'b10
  } bops_mode_t;

endpackage : bops_pkg

/* bops_sequencer.sv */
`timescale 1ns/10ps
`include "bops_defines.svh"
module bops_sequencer (
  // Clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Supply comparators
  input  wire logic        vcc_above_sel_start,
  input  wire logic        vcc_above_on,
  input  wire logic        vcc_below_off,
  input  wire logic        vcc_above_ovp,
  // Selection comparators
  input  wire logic        fb_above_sel_bias1,
  input  wire logic        fb_above_sel_bias2,
  input  wire logic        error_input_pin_above_bias,
  // Feedback comparators
  input  wire logic        fb_below_entry,
  input  wire logic        fb_above_exit,
  input  wire logic        fb_above_burst_on,
  input  wire logic        fb_below_burst_off,
  input  wire logic        fb_above_overload,
  // Current sense, gate, temperature
  input  wire logic        cs_below_short,
  input  wire logic        gate_on,
  input  wire logic        temp_over,
  input  wire logic        temp_recovered,
  // Selection outputs
  output logic             sel_current_en,
  output logic             fb_pullup_en,
  output logic             err_bias_en,
  output logic             err_amp_connect,
  output bops_pkg::bops_opt_t burst_option,
  // Operating outputs
  output logic             switch_en,
  output logic             soft_start,
  output logic             burst_light_load_mode,
  output logic [11:0]      burst_peak_current_level,
  output logic [11:0]      burst_entry_level,
  output logic [11:0]      burst_exit_level,
  output bops_pkg::bops_state_t state,
  output bops_pkg::bops_mode_t  restart_mode
);

  bops_pkg::bops_state_t state_ff, nxt_state;
  bops_pkg::bops_opt_t   opt_ff, nxt_opt;
  bops_pkg::bops_mode_t  mode_ff, nxt_mode;
  logic        sel_done_ff, nxt_sel_done;
  logic        non_iso_ff, nxt_non_iso;
  logic        skip_done_ff, nxt_skip_done;
  logic [11:0] rst_cnt_ff, nxt_rst_cnt;
  logic        ss_ff, nxt_ss;
  logic        gate_d_ff, nxt_gate_d;
  logic        bad_pulse_ff, nxt_bad_pulse;
  logic [1:0]  short_cnt_ff, nxt_short_cnt;
  logic        uv_exp, ovp_exp, olp_exp, burst_exp, cs_exp;
  logic        chk_ovp_cs, chk_olp, pulse_end, short_fault;

  // Check enables per state; undervoltage and temperature watched in every state but ST_SELECT
  assign chk_ovp_cs = (state_ff == bops_pkg::ST_NORMAL) || (state_ff == bops_pkg::ST_BURST_ON);
  assign chk_olp    = (state_ff == bops_pkg::ST_NORMAL);

  // Blanking timers
  bops_blank_timer #(.LIMIT(`BOPS_N_UV)) u_uv (
    .clk_sys (clk_sys), .srst (srst), .clk_en (clk_en),
    .cond    (vcc_below_off && state_ff != bops_pkg::ST_SELECT), .expired (uv_exp));
  bops_blank_timer #(.LIMIT(`BOPS_N_OVP)) u_ovp (
    .clk_sys (clk_sys), .srst (srst), .clk_en (clk_en),
    .cond    (vcc_above_ovp && chk_ovp_cs), .expired (ovp_exp));
  bops_blank_timer #(.LIMIT(`BOPS_N_OLP)) u_olp (
    .clk_sys (clk_sys), .srst (srst), .clk_en (clk_en),
    .cond    (fb_above_overload && chk_olp), .expired (olp_exp));
  bops_blank_timer #(.LIMIT(`BOPS_N_BURST)) u_burst (
    .clk_sys (clk_sys), .srst (srst), .clk_en (clk_en),
    .cond    (fb_below_entry && chk_olp && opt_ff != bops_pkg::OPT_NONE),
    .expired (burst_exp));
  bops_blank_timer #(.LIMIT(`BOPS_N_CS_BLANK)) u_cs (
    .clk_sys (clk_sys), .srst (srst), .clk_en (clk_en),
    .cond    (gate_on && cs_below_short && chk_ovp_cs), .expired (cs_exp));

  // A pulse ends on the falling gate edge; short fault on the third bad one
  assign pulse_end   = gate_d_ff && !gate_on;
  assign short_fault = pulse_end && (bad_pulse_ff || cs_exp)
                       && (short_cnt_ff == `BOPS_SHORT_PULSES - 2'h1);

  // Short-to-ground pulse tracking
  always_comb begin
    nxt_gate_d    = gate_on;
    nxt_bad_pulse = bad_pulse_ff || cs_exp;
    nxt_short_cnt = short_cnt_ff;
    if (pulse_end) begin
      nxt_bad_pulse = 1'b0;
      // A blank expiring on the last on-cycle still marks the pulse bad
      nxt_short_cnt = (bad_pulse_ff || cs_exp) ? short_cnt_ff + 2'h1 : 2'h0;
    end
    if (!chk_ovp_cs || short_fault) begin
      nxt_bad_pulse = 1'b0;
      nxt_short_cnt = 2'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gate_d_ff    <= 1'b0;
      bad_pulse_ff <= 1'b0;
      short_cnt_ff <= 2'h0;
    end else if (clk_en) begin
      gate_d_ff    <= nxt_gate_d;
      bad_pulse_ff <= nxt_bad_pulse;
      short_cnt_ff <= nxt_short_cnt;
    end
  end

  // Main sequence: selection, burst, faults and restarts
  always_comb begin
    nxt_state     = state_ff;
    nxt_opt       = opt_ff;
    nxt_mode      = mode_ff;
    nxt_sel_done  = sel_done_ff;
    nxt_non_iso   = non_iso_ff;
    nxt_skip_done = skip_done_ff;
    nxt_rst_cnt   = 12'h000;
    nxt_ss        = 1'b0;
    unique case (state_ff)
      bops_pkg::ST_SELECT: begin
        if (vcc_above_on) begin
          if (!sel_done_ff) begin
            // Sample once; never revisited after this edge
            nxt_opt      = !fb_above_sel_bias1 ? bops_pkg::OPT_NONE :
                           (fb_above_sel_bias2 ? bops_pkg::OPT_HIGH : bops_pkg::OPT_LOW);
            nxt_non_iso  = error_input_pin_above_bias;
            nxt_sel_done = 1'b1;
          end
          nxt_state = bops_pkg::ST_NORMAL;
          nxt_ss    = 1'b1;
        end
      end
      bops_pkg::ST_NORMAL: begin
        if (burst_exp) begin
          nxt_state = bops_pkg::ST_BURST_ON;
        end
      end
      bops_pkg::ST_BURST_ON: begin
        if (fb_above_exit) begin
          nxt_state = bops_pkg::ST_NORMAL;
        end else if (fb_below_burst_off) begin
          nxt_state = bops_pkg::ST_BURST_OFF;
        end
      end
      bops_pkg::ST_BURST_OFF: begin
        if (fb_above_exit) begin
          nxt_state = bops_pkg::ST_NORMAL;
        end else if (fb_above_burst_on) begin
          nxt_state = bops_pkg::ST_BURST_ON;
        end
      end
      bops_pkg::ST_RESTART: begin
        nxt_rst_cnt = (rst_cnt_ff == `BOPS_N_RESTART) ? rst_cnt_ff : rst_cnt_ff + 12'h001;
        if (mode_ff == bops_pkg::AR_NON_SWITCH) begin
          if (temp_recovered && rst_cnt_ff == `BOPS_N_RESTART) begin
            nxt_state = bops_pkg::ST_NORMAL;
            nxt_ss    = 1'b1;
          end
        end else if (rst_cnt_ff == `BOPS_N_RESTART) begin
          nxt_rst_cnt = 12'h000;
          if (mode_ff == bops_pkg::AR_ODD_SKIP && !skip_done_ff) begin
            nxt_skip_done = 1'b1;
          end else begin
            nxt_skip_done = 1'b0;
            nxt_state     = bops_pkg::ST_NORMAL;
            nxt_ss        = 1'b1;
          end
        end
      end
      default: nxt_state = bops_pkg::ST_SELECT;
    endcase
    // Fault entry, highest priority last so it wins
    if (olp_exp || short_fault || ovp_exp) begin
      nxt_state     = bops_pkg::ST_RESTART;
      nxt_mode      = bops_pkg::AR_ODD_SKIP;
      nxt_rst_cnt   = 12'h000;
      nxt_skip_done = 1'b0;
      nxt_ss        = 1'b0;
    end
    if (temp_over && state_ff != bops_pkg::ST_SELECT) begin
      nxt_state   = bops_pkg::ST_RESTART;
      nxt_mode    = bops_pkg::AR_NON_SWITCH;
      nxt_rst_cnt = 12'h000;
      nxt_ss      = 1'b0;
    end
    if (uv_exp) begin
      nxt_state = bops_pkg::ST_SELECT;
      nxt_mode  = bops_pkg::AR_PLAIN;
      nxt_ss    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_ff     <= bops_pkg::ST_SELECT;
      opt_ff       <= bops_pkg::OPT_HIGH;
      mode_ff      <= bops_pkg::AR_PLAIN;
      sel_done_ff  <= 1'b0;
      non_iso_ff   <= 1'b0;
      skip_done_ff <= 1'b0;
      rst_cnt_ff   <= 12'h000;
      ss_ff        <= 1'b0;
    end else if (clk_en) begin
      state_ff     <= nxt_state;
      opt_ff       <= nxt_opt;
      mode_ff      <= nxt_mode;
      sel_done_ff  <= nxt_sel_done;
      non_iso_ff   <= nxt_non_iso;
      skip_done_ff <= nxt_skip_done;
      rst_cnt_ff   <= nxt_rst_cnt;
      ss_ff        <= nxt_ss;
    end
  end

  // Output registers, all derived from next-state values so they track state_ff
  logic        out_sel_ff, out_pull_ff, out_ebias_ff, out_amp_ff, out_sw_ff, out_burst_ff;
  logic [11:0] out_peak_ff, out_entry_ff, out_exit_ff;
  logic        nxt_burst;
  logic [11:0] nxt_peak, nxt_entry, nxt_exit;

  always_comb begin
    nxt_burst = (nxt_state == bops_pkg::ST_BURST_ON) || (nxt_state == bops_pkg::ST_BURST_OFF);
    unique case (nxt_opt)
      bops_pkg::OPT_LOW: begin
        nxt_peak  = `BOPS_MV_PEAK_LOW;
        nxt_entry = `BOPS_MV_ENTRY_LOW;
        nxt_exit  = `BOPS_MV_EXIT;
      end
      bops_pkg::OPT_HIGH: begin
        nxt_peak  = `BOPS_MV_PEAK_HIGH;
        nxt_entry = `BOPS_MV_ENTRY_HIGH;
        nxt_exit  = `BOPS_MV_EXIT;
      end
      default: begin
        nxt_peak  = `BOPS_MV_NONE;
        nxt_entry = `BOPS_MV_NONE;
        nxt_exit  = `BOPS_MV_NONE;
      end
    endcase
    // Zero peak level means the normal threshold applies
    if (!nxt_burst) begin
      nxt_peak = `BOPS_MV_NONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_sel_ff   <= 1'b0;
      out_pull_ff  <= 1'b0;
      out_ebias_ff <= 1'b1;
      out_amp_ff   <= 1'b0;
      out_sw_ff    <= 1'b0;
      out_burst_ff <= 1'b0;
      out_peak_ff  <= `BOPS_MV_NONE;
      out_entry_ff <= `BOPS_MV_NONE;
      out_exit_ff  <= `BOPS_MV_NONE;
    end else if (clk_en) begin
      out_sel_ff   <= !nxt_sel_done && vcc_above_sel_start;
      out_pull_ff  <= nxt_sel_done;
      out_ebias_ff <= !nxt_sel_done;
      out_amp_ff   <= nxt_sel_done && nxt_non_iso;
      out_sw_ff    <= (nxt_state == bops_pkg::ST_NORMAL) || (nxt_state == bops_pkg::ST_BURST_ON);
      out_burst_ff <= nxt_burst;
      out_peak_ff  <= nxt_peak;
      out_entry_ff <= nxt_entry;
      out_exit_ff  <= nxt_exit;
    end
  end

  assign sel_current_en           = out_sel_ff;
  assign fb_pullup_en             = out_pull_ff;
  assign err_bias_en              = out_ebias_ff;
  assign err_amp_connect          = out_amp_ff;
  assign burst_option             = opt_ff;
  assign switch_en                = out_sw_ff;
  assign soft_start               = ss_ff;
  assign burst_light_load_mode    = out_burst_ff;
  assign burst_peak_current_level = out_peak_ff;
  assign burst_entry_level        = out_entry_ff;
  assign burst_exit_level         = out_exit_ff;
  assign state                    = state_ff;
  assign restart_mode             = mode_ff;

  // Checks on the sequence
  property p_opt_latched;
    @(posedge clk_sys) disable iff (srst) sel_done_ff |=> $stable(opt_ff) && sel_done_ff;
  endproperty
  a_opt_latched: assert property (p_opt_latched) else $error("burst option changed after latch");

  property p_preset;
    @(posedge clk_sys) srst ##1 !srst |-> opt_ff == bops_pkg::OPT_HIGH && !fb_pullup_en;
  endproperty
  a_preset: assert property (p_preset) else $error("preset after reset wrong");

  property p_low_levels;
    @(posedge clk_sys) disable iff (srst)
      burst_light_load_mode && opt_ff == bops_pkg::OPT_LOW |-> burst_peak_current_level == 12'h0dc
      && burst_entry_level == 12'h3a2 && burst_exit_level == 12'haaa;
  endproperty
  a_low_levels: assert property (p_low_levels) else $error("low option levels wrong");

  property p_high_levels;
    @(posedge clk_sys) disable iff (srst)
      burst_light_load_mode && opt_ff == bops_pkg::OPT_HIGH |-> burst_peak_current_level == 12'h10e
      && burst_entry_level == 12'h406;
  endproperty
  a_high_levels: assert property (p_high_levels) else $error("high option levels wrong");

  property p_amp;
    @(posedge clk_sys) disable iff (srst) sel_done_ff ##1 clk_en |-> err_amp_connect == non_iso_ff;
  endproperty
  a_amp: assert property (p_amp) else $error("amplifier connection mismatches mode");

  property p_uv_off;
    @(posedge clk_sys) disable iff (srst) clk_en && uv_exp |=> !switch_en && state_ff == bops_pkg::ST_SELECT;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("switch not held off on undervoltage");

  property p_exit;
    @(posedge clk_sys) disable iff (srst)
      clk_en && state_ff == bops_pkg::ST_BURST_OFF && fb_above_exit && !uv_exp && !temp_over
      |=> state_ff == bops_pkg::ST_NORMAL && burst_peak_current_level == 12'h000;
  endproperty
  a_exit: assert property (p_exit) else $error("burst exit not immediate");

  property p_soft;
    @(posedge clk_sys) disable iff (srst)
      clk_en && state_ff == bops_pkg::ST_RESTART && nxt_state == bops_pkg::ST_NORMAL |=> soft_start;
  endproperty
  a_soft: assert property (p_soft) else $error("restart without soft start");

  property p_no_olp_burst;
    @(posedge clk_sys) disable iff (srst)
      state_ff == bops_pkg::ST_BURST_ON ##1 state_ff == bops_pkg::ST_BURST_ON |-> !olp_exp;
  endproperty
  a_no_olp_burst: assert property (p_no_olp_burst) else $error("overload checked in burst");

  property p_otp_hold;
    @(posedge clk_sys) disable iff (srst)
      clk_en && state_ff == bops_pkg::ST_RESTART && mode_ff == bops_pkg::AR_NON_SWITCH && !temp_recovered
      && !uv_exp |=> state_ff == bops_pkg::ST_RESTART && !switch_en;
  endproperty
  a_otp_hold: assert property (p_otp_hold) else $error("left overtemperature before recovery");

  property p_short;
    @(posedge clk_sys) disable iff (srst)
      clk_en && short_fault && !uv_exp && !temp_over |=> state_ff == bops_pkg::ST_RESTART
      && mode_ff == bops_pkg::AR_ODD_SKIP;
  endproperty
  a_short: assert property (p_short) else $error("third short pulse missed");

endmodule : bops_sequencer

/* bops_sequencer_tb_top.sv */
`timescale 1ns/10ps
module bops_sequencer_tb_top;
  // Bench-driven inputs
  logic        clk_sys, srst, clk_en, temp_over, temp_recovered, cs_below_short;
  logic [15:0] vcc_mv;
  logic [11:0] fb_mv, err_mv, fb_n, err_n;
  // Stage model results
  logic        vcc_above_sel_start, vcc_above_on, vcc_below_off, vcc_above_ovp, gate_on;
  logic        fb_above_sel_bias1, fb_above_sel_bias2, error_input_pin_above_bias;
  logic        fb_below_entry, fb_above_exit, fb_above_burst_on, fb_below_burst_off, fb_above_overload;
  // Device outputs
  logic        sel_current_en, fb_pullup_en, err_bias_en, err_amp_connect, switch_en, soft_start;
  logic        burst_light_load_mode;
  logic [11:0] burst_peak_current_level, burst_entry_level, burst_exit_level;
  logic [1:0]  opt_n;
  bops_pkg::bops_opt_t   burst_option;
  bops_pkg::bops_state_t state;
  bops_pkg::bops_mode_t  restart_mode;
  int          failures, comparisons, soft_starts, s0;

  bops_sequencer bops_sequencer_i (.*);
  bops_stage_model bops_stage_model_i (.*);

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Soft starts are single-cycle pulses, so count them as they pass
  always @(posedge clk_sys) if (soft_start === 1'b1) soft_starts++;

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Bounded wait on the state matching or leaving a value
  task automatic wait_state(input bops_pkg::bops_state_t s, input logic eq, input int maxc);
    for (int n = 0; ((state === s) !== eq) && (n < maxc); n++) @(posedge clk_sys);
  endtask : wait_state

  function automatic logic [11:0] entry_for(input logic [1:0] o);
    return (o == 2'h1) ? 12'h3a2 : (o == 2'h2) ? 12'h406 : 12'h000;
  endfunction : entry_for

  task automatic reset_dut();
    srst <= 1'b1;
    vcc_mv <= 16'h0000;
    cyc(10);
    srst <= 1'b0;
    cyc(1);
  endtask : reset_dut

  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Watchdog well beyond the longest expected run
  initial begin
    cyc(60000);
    failures++;
    $display("mismatch watchdog expected 0 seen 1");
    finish_test();
  end

  initial begin
    {clk_en, temp_over, temp_recovered, cs_below_short} = 4'b1000;
    {fb_mv, err_mv} = '0;
    void'($urandom(32));
    // Selection: none, low, high, with random isolation
    for (int i = 0; i < 3; i++) begin
      reset_dut();
      check("preset option", 12'(burst_option), 12'h002);
      check("error bias", 12'(err_bias_en), 12'h001);
      fb_n = 12'(i * 1000 + 100 + $urandom % 800);
      err_n = 12'($urandom % 400);
      opt_n = 2'(i);
      vcc_mv <= 16'd5000;
      fb_mv <= fb_n;
      err_mv <= err_n;
      cyc(5);
      check("select current", 12'(sel_current_en), 12'h001);
      check("pull-up off", 12'(fb_pullup_en), 12'h000);
      s0 = soft_starts;
      vcc_mv <= 16'd12500;
      wait_state(bops_pkg::ST_SELECT, 1'b0, 20);
      cyc(2);
      check("option", 12'(burst_option), 12'(opt_n));
      check("entry", burst_entry_level, entry_for(opt_n));
      check("exit", burst_exit_level, (opt_n != 2'h0) ? 12'haaa : 12'h000);
      check("amp link", 12'(err_amp_connect), 12'(err_n > 12'h0c8));
      check("current off", 12'(sel_current_en), 12'h000);
      check("pull-up on", 12'(fb_pullup_en), 12'h001);
      check("bias off", 12'(err_bias_en), 12'h000);
      check("soft start", 12'(soft_starts - s0), 12'h001);
      fb_mv <= 12'h7d0;
      cyc(5);
      check("option kept", 12'(burst_option), 12'(opt_n));
      $display("selection case %0d done", i);
      // Burst per live option: short dip ignored, long dip enters, off/on phases, exit leaves
      if (opt_n != 2'h0) begin
        fb_mv <= 12'h384;
        cyc(100 + $urandom % 600);
        fb_mv <= 12'h7d0;
        cyc(3);
        check("dip ignored", 12'(burst_light_load_mode), 12'h000);
        fb_mv <= 12'h384;
        wait_state(bops_pkg::ST_NORMAL, 1'b0, 900);
        cyc(2);
        check("burst mode", 12'(burst_light_load_mode), 12'h001);
        check("burst peak", burst_peak_current_level, (opt_n == 2'h1) ? 12'h0dc : 12'h10e);
        fb_mv <= 12'h2bc;
        cyc(2);
        check("burst off", 12'({state, switch_en}), 12'({bops_pkg::ST_BURST_OFF, 1'b0}));
        fb_mv <= 12'h514;
        cyc(2);
        check("burst on", 12'({state, switch_en}), 12'({bops_pkg::ST_BURST_ON, 1'b1}));
        fb_mv <= 12'h2bc;
        cyc(2);
        // Exit level seen while frozen must wait for the enable
        clk_en <= 1'b0;
        fb_mv <= 12'haf0;
        cyc(3);
        check("frozen", 12'(burst_light_load_mode), 12'h001);
        clk_en <= 1'b1;
        cyc(2);
        check("burst left", 12'(burst_light_load_mode), 12'h000);
        check("normal peak", burst_peak_current_level, 12'h000);
        fb_mv <= 12'h7d0;
        cyc(1);
        $display("burst test done");
      end
    end
    // Overload: brief excursion tolerated, long one restarts skipping once
    fb_mv <= 12'hbb8;
    cyc(700);
    fb_mv <= 12'h7d0;
    cyc(5);
    check("peak load", 12'(state), 12'(bops_pkg::ST_NORMAL));
    fb_mv <= 12'hbb8;
    wait_state(bops_pkg::ST_RESTART, 1'b1, 900);
    check("overload mode", 12'(restart_mode), 12'(bops_pkg::AR_ODD_SKIP));
    fb_mv <= 12'h7d0;
    s0 = soft_starts;
    cyc(4100);
    check("skipped", 12'({state, switch_en}), 12'({bops_pkg::ST_RESTART, 1'b0}));
    wait_state(bops_pkg::ST_NORMAL, 1'b1, 4100);
    cyc(2);
    check("restarted", 12'(soft_starts - s0), 12'h001);
    $display("overload test done");
    // Overtemperature holds off until recovery
    temp_over <= 1'b1;
    wait_state(bops_pkg::ST_RESTART, 1'b1, 5);
    check("hot mode", 12'(restart_mode), 12'(bops_pkg::AR_NON_SWITCH));
    temp_over <= 1'b0;
    cyc(5000);
    check("hot wait", 12'({state, switch_en}), 12'({bops_pkg::ST_RESTART, 1'b0}));
    temp_recovered <= 1'b1;
    wait_state(bops_pkg::ST_NORMAL, 1'b1, 4100);
    check("cool", 12'(state), 12'(bops_pkg::ST_NORMAL));
    temp_recovered <= 1'b0;
    $display("temperature test done");
    // Shorted sense for three pulses
    cs_below_short <= 1'b1;
    wait_state(bops_pkg::ST_RESTART, 1'b1, 160);
    check("short mode", 12'(restart_mode), 12'(bops_pkg::AR_ODD_SKIP));
    cs_below_short <= 1'b0;
    wait_state(bops_pkg::ST_NORMAL, 1'b1, 8200);
    check("short back", 12'(state), 12'(bops_pkg::ST_NORMAL));
    $display("short test done");
    // Overvoltage: 2100 cycles survives, past 2200 restarts skipping once
    vcc_mv <= 16'd26000;
    cyc(2100);
    check("ovp early", 12'(switch_en), 12'h001);
    wait_state(bops_pkg::ST_RESTART, 1'b1, 200);
    check("ovp off", 12'({state, switch_en}), 12'({bops_pkg::ST_RESTART, 1'b0}));
    check("ovp mode", 12'(restart_mode), 12'(bops_pkg::AR_ODD_SKIP));
    vcc_mv <= 16'd12500;
    wait_state(bops_pkg::ST_NORMAL, 1'b1, 8200);
    check("ovp back", 12'(state), 12'(bops_pkg::ST_NORMAL));
    $display("overvoltage test done");
    // Undervoltage: held 1900 cycles survives, past 2000 restarts startup
    vcc_mv <= 16'd9000;
    cyc(1900);
    check("uv early", 12'(switch_en), 12'h001);
    wait_state(bops_pkg::ST_SELECT, 1'b1, 200);
    check("uv off", 12'({state, switch_en}), 12'({bops_pkg::ST_SELECT, 1'b0}));
    s0 = soft_starts;
    vcc_mv <= 16'd12500;
    wait_state(bops_pkg::ST_NORMAL, 1'b1, 100);
    cyc(2);
    check("uv soft", 12'(soft_starts - s0), 12'h001);
    check("uv option", 12'(burst_option), 12'h002);
    $display("undervoltage test done");
    finish_test();
  end
endmodule : bops_sequencer_tb_top

/* bops_stage_model.sv */
`timescale 1ns/10ps
module bops_stage_model #(
  parameter int SEL_MV   = 4440,
  parameter int ON_MV    = 12000,
  parameter int OFF_MV   = 10000,
  parameter int OVP_MV   = 25500,
  parameter int BIAS1_MV = 1000,
  parameter int BIAS2_MV = 2000,
  parameter int BON_MV   = 1200,
  parameter int BOFF_MV  = 800,
  parameter int OLP_MV   = 2900
) (
  // Clock
  input  wire logic        clk_sys,
  // Pin levels in millivolts
  input  wire logic [15:0] vcc_mv,
  input  wire logic [11:0] fb_mv,
  input  wire logic [11:0] err_mv,
  // Device state seen by the stage
  input  wire logic        switch_en,
  input  wire logic [11:0] burst_entry_level,
  input  wire logic [11:0] burst_exit_level,
  // Comparator results
  output logic             vcc_above_sel_start,
  output logic             vcc_above_on,
  output logic             vcc_below_off,
  output logic             vcc_above_ovp,
  output logic             fb_above_sel_bias1,
  output logic             fb_above_sel_bias2,
  output logic             error_input_pin_above_bias,
  output logic             fb_below_entry,
  output logic             fb_above_exit,
  output logic             fb_above_burst_on,
  output logic             fb_below_burst_off,
  output logic             fb_above_overload,
  output logic             gate_on
);
  logic [5:0] phase_ff = 6'h00;

  // Supply comparators
  assign vcc_above_sel_start = vcc_mv > SEL_MV;
  assign vcc_above_on        = vcc_mv > ON_MV;
  assign vcc_below_off       = vcc_mv < OFF_MV;
  assign vcc_above_ovp       = vcc_mv > OVP_MV;
  // Selection levels from select resistor and error divider
  assign fb_above_sel_bias1         = fb_mv > BIAS1_MV;
  assign fb_above_sel_bias2         = fb_mv > BIAS2_MV;
  assign error_input_pin_above_bias = err_mv > 12'h0c8;
  // Feedback against entry and exit levels the device chose and fixed burst and overload levels; zero level never trips
  assign fb_below_entry     = fb_mv < burst_entry_level;
  assign fb_above_exit      = (burst_exit_level != 12'h000) && (fb_mv > burst_exit_level);
  assign fb_above_burst_on  = fb_mv > BON_MV;
  assign fb_below_burst_off = fb_mv < BOFF_MV;
  assign fb_above_overload  = fb_mv > OLP_MV;
  // Switch pulses only while allowed, 20 on out of 40
  always_ff @(posedge clk_sys) begin
    phase_ff <= (phase_ff == 6'h27) ? 6'h00 : phase_ff + 6'h01;
  end
  assign gate_on = switch_en && (phase_ff < 6'h14);
endmodule : bops_stage_model
